// [hdl/l1rmh_map.svh]
// Offsets, field positions, reset values and counts of the reload handler
`ifndef L1RMH_MAP_SVH
`define L1RMH_MAP_SVH
`define L1RMH_CTRL_OFS   4'h0
`define L1RMH_STAT_OFS   4'h4
`define L1RMH_L2EN_RST   1'h0
`define L1RMH_L2EN_BIT   0
`define L1RMH_ST_LFQ     8
`define L1RMH_ST_IFB     12
`define L1RMH_NENT       8
`define L1RMH_NLFQ       4
`define L1RMH_ZHIT_GAP   2'h3
`define L1RMH_LAST_BEAT  2'h3
`define L1RMH_BLK_FULL   32'hFFFFFFFF
`define L1RMH_DW_BYTES   32'h000000FF
`endif

// [hdl/l1rmh_pkg.sv]
// Types shared by the reload handler modules
package l1rmh_pkg;
  typedef enum logic [3:0] {
    RQ_NONE  = 4'h1,
    RQ_WAIT  = 4'h2,
    RQ_GRANT = 4'h4,
    RQ_REPL  = 4'h8
  } l1rmh_rq_t;
  typedef enum logic [1:0] {
    BK_READ   = 2'h0,
    BK_RWITM  = 2'h1,
    BK_KILL   = 2'h2,
    BK_CANCEL = 2'h3
  } l1rmh_bk_t;
  typedef enum logic [1:0] {
    IF_IDLE = 2'h1,
    IF_FILL = 2'h2
  } l1rmh_ifs_t;
endpackage

// [hdl/l1rmh_rdb_if.sv]
// Port bundle between the handler and its reload data buffer
`timescale 1ns/100ps
interface l1rmh_rdb_if;
  logic         we;
  logic [2:0]   wentry;
  logic [31:0]  wmask;
  logic [255:0] wdata;
  logic         re;
  logic [2:0]   rentry;
  logic [255:0] rdata;
  modport ctl (output we, wentry, wmask, wdata, re, rentry, input rdata);
  modport mem (input we, wentry, wmask, wdata, re, rentry, output rdata);
endinterface

// [hdl/l1rmh_rdb.sv]
// Reload data buffer: eight 32-byte entries, byte writes, registered read
`timescale 1ns/100ps
module l1rmh_rdb (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  l1rmh_rdb_if.mem rdb
);
  logic [255:0] rword;
  genvar        gb;

  for (gb = 0; gb < 32; gb++)
  begin : g_byte
    logic [7:0] mem [8];
    always_ff @(posedge ref_clk)
    begin
      if (ce && rdb.we && rdb.wmask[gb])
      begin
        mem[rdb.wentry] <= rdb.wdata[8*gb +: 8];
      end
    end
    assign rword[8*gb +: 8] = mem[rdb.rentry];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      rdb.rdata <= 256'h0;
    end
    else if (ce && rdb.re)
    begin
      rdb.rdata <= rword;
    end
  end
endmodule

// [hdl/l1rmh_ifill.sv]
// Instruction cache fill sequencer, critical double word first
`timescale 1ns/100ps
`include "l1rmh_map.svh"
module l1rmh_ifill
  import l1rmh_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        imiss_valid,
  input  wire logic [1:0]  imiss_crit,
  input  wire logic        imiss_l2miss,
  input  wire logic        beat_valid,
  input  wire logic [63:0] beat_data,
  input  wire logic        ihit_req,
  output      logic        ic_wr,
  output      logic [1:0]  ic_widx,
  output      logic [63:0] ic_wdata,
  output      logic        iq_valid,
  output      logic [63:0] iq_data,
  output      logic        l2_alloc,
  output      logic        ihit_ack,
  output      logic        busy
);
  l1rmh_ifs_t st;
  l1rmh_ifs_t next_st;
  logic [1:0] idx;
  logic [1:0] next_idx;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic       take;

  assign take = (st == IF_FILL) && beat_valid;

  always_comb
  begin
    next_st  = st;
    next_idx = idx;
    next_cnt = cnt;
    case (st)
      IF_IDLE:
      begin
        if (imiss_valid)
        begin
          next_st  = IF_FILL;
          next_idx = imiss_crit;
          next_cnt = 2'h0;
        end
      end
      IF_FILL:
      begin
        if (beat_valid)
        begin
          next_idx = idx + 2'h1;
          next_cnt = cnt + 2'h1;
          if (cnt == `L1RMH_LAST_BEAT)
          begin
            next_st = IF_IDLE;
          end
        end
      end
      default:
      begin
        next_st = IF_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st       <= IF_IDLE;
      idx      <= 2'h0;
      cnt      <= 2'h0;
      ic_wr    <= 1'h0;
      ic_widx  <= 2'h0;
      ic_wdata <= 64'h0;
      iq_valid <= 1'h0;
      iq_data  <= 64'h0;
      l2_alloc <= 1'h0;
      ihit_ack <= 1'h0;
      busy     <= 1'h0;
    end
    else if (ce)
    begin
      st       <= next_st;
      idx      <= next_idx;
      cnt      <= next_cnt;
      ic_wr    <= take;
      ic_widx  <= idx;
      ic_wdata <= beat_data;
      iq_valid <= take;
      iq_data  <= beat_data;
      l2_alloc <= (st == IF_IDLE) && imiss_valid && imiss_l2miss;
      ihit_ack <= ihit_req;
      busy     <= (next_st == IF_FILL);
    end
  end
endmodule

// [hdl/l1rmh_top.sv]
// L1 reload and miss handler: reload table, fold queue, castout choice
// Operation
// - Data cache fills only from eight 32-byte reload buffer entries.
// - Load or write-back store miss starts a fill after coherency.
// - Instruction fill is four 64-bit beats, critical double word first.
// - Instruction cache keeps serving hits during a miss fill.
// - Each fill beat written to cache and instruction queue together.
// - Instruction miss allocates in L2 too when L2 misses.
// - Data miss allocates only in data cache; L2 takes castouts only.
// - Valid victim with castout or dirty flag is queued as castout.
// - L2 on: miss allocates only with castout flag, else modified to bus.
// - L2 off: replaced block goes to bus only when modified.
// - Cacheable load or store miss claims a reload table entry.
// - Matching later load folds into four-entry queue, reads buffer.
// - Inhibited loads take an entry; nothing folds into it.
// - Store miss writes buffer; fill completes rest; reload at 32 bytes.
// - Later store miss merges into store entry, reuses its coherency.
// - Merged block reloads after coherency done and all bytes valid.
// - Fully written non-global store entry reloads at once.
// - Full entry not yet at queue bottom drops its fill request.
// - At bottom without grant kill replaces; granted data is discarded.
// - Store hits pipelined; zero or allocate hits once per four cycles.
// - Store hit on shared block merges, kills, reloads modified.
// - Snoop loss before kill turns entry into ordinary store miss.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "l1rmh_map.svh"
module l1rmh_top
  import l1rmh_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output      logic [31:0]  reg_rdata,
  input  wire logic         miss_valid,
  input  wire logic         miss_store,
  input  wire logic         miss_sr,
  input  wire logic         miss_ci,
  input  wire logic         miss_gbl,
  input  wire logic [26:0]  miss_addr,
  input  wire logic [1:0]   miss_dw,
  input  wire logic [7:0]   miss_be,
  input  wire logic [63:0]  miss_wdata,
  input  wire logic [255:0] miss_line,
  input  wire logic [3:0]   miss_tag,
  output      logic         miss_ack,
  input  wire logic         fill_valid,
  input  wire logic         fill_last,
  input  wire logic [2:0]   fill_entry,
  input  wire logic [1:0]   fill_beat,
  input  wire logic [63:0]  fill_data,
  input  wire logic         bq_bot_valid,
  input  wire logic [2:0]   bq_bot_entry,
  input  wire logic         bq_grant,
  input  wire logic         coh_ok,
  input  wire logic [2:0]   coh_entry,
  input  wire logic         snoop_lose,
  input  wire logic [2:0]   snoop_entry,
  output      logic         breq_valid,
  output      logic [2:0]   breq_entry,
  output      l1rmh_bk_t    breq_kind,
  output      logic [26:0]  breq_addr,
  output      logic         rld_valid,
  output      logic [26:0]  rld_addr,
  output      logic [255:0] rld_data,
  output      logic         rld_mcd,
  output      logic         res_valid,
  output      logic [3:0]   res_tag,
  output      logic [63:0]  res_data,
  input  wire logic         vic_valid,
  input  wire logic         vic_c,
  input  wire logic         vic_d,
  input  wire logic         vic_m,
  input  wire logic         vic_l2hit,
  output      logic         co_valid,
  output      logic         co_l2_write,
  output      logic         co_l2_new_tag,
  output      logic         co_sys,
  input  wire logic         sthit_req,
  output      logic         sthit_ack,
  input  wire logic         zhit_req,
  output      logic         zhit_ack,
  input  wire logic         imiss_valid,
  input  wire logic [1:0]   imiss_crit,
  input  wire logic         imiss_l2miss,
  input  wire logic         ibeat_valid,
  input  wire logic [63:0]  ibeat_data,
  input  wire logic         ihit_req,
  output      logic         ic_wr,
  output      logic [1:0]   ic_widx,
  output      logic [63:0]  ic_wdata,
  output      logic         iq_valid,
  output      logic [63:0]  iq_data,
  output      logic         il2_alloc,
  output      logic         ihit_ack
);
  logic [7:0]   ev, eci, est, egbl, esr, ecoh, epend;
  logic [7:0]   next_ev, next_eci, next_est, next_egbl;
  logic [7:0]   next_esr, next_ecoh, next_epend;
  logic [26:0]  eaddr [8];
  logic [26:0]  next_eaddr [8];
  logic [31:0]  ebv [8];
  logic [31:0]  next_ebv [8];
  logic [31:0]  esm [8];
  logic [31:0]  next_esm [8];
  l1rmh_rq_t    erq [8];
  l1rmh_rq_t    next_erq [8];
  l1rmh_bk_t    epk [8];
  l1rmh_bk_t    next_epk [8];
  logic [3:0]   lv, next_lv;
  logic [2:0]   ltag [4];
  logic [2:0]   next_ltag [4];
  logic [1:0]   ldw [4];
  logic [1:0]   next_ldw [4];
  logic [7:0]   lbe [4];
  logic [7:0]   next_lbe [4];
  logic [3:0]   lid [4];
  logic [3:0]   next_lid [4];
  logic         s1v, next_s1v;
  logic [1:0]   s1dw, next_s1dw;
  logic [3:0]   s1id, next_s1id;
  logic         next_ack, next_bv, next_rv, next_mcd;
  logic [2:0]   next_be;
  l1rmh_bk_t    next_bk;
  logic [26:0]  next_ba, next_ra;
  logic [7:0]   hit, full, rdy, lref;
  logic [31:0]  smask, fmask;
  logic [255:0] sbits;
  logic         l2en, ifb;
  logic [1:0]   zcnt, next_zcnt;
  logic         mh, ff, lf, rf, qf, pf;
  logic [2:0]   hidx, fidx, ridx, pidx;
  logic [1:0]   lfidx, qidx;
  logic [7:0]   bvq;
  genvar        gi;

  l1rmh_rdb_if rdb ();

  l1rmh_rdb u_rdb (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .rdb     (rdb.mem)
  );

  l1rmh_ifill u_ifill (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .ce           (ce),
    .imiss_valid  (imiss_valid),
    .imiss_crit   (imiss_crit),
    .imiss_l2miss (imiss_l2miss),
    .beat_valid   (ibeat_valid),
    .beat_data    (ibeat_data),
    .ihit_req     (ihit_req),
    .ic_wr        (ic_wr),
    .ic_widx      (ic_widx),
    .ic_wdata     (ic_wdata),
    .iq_valid     (iq_valid),
    .iq_data      (iq_data),
    .l2_alloc     (il2_alloc),
    .ihit_ack     (ihit_ack),
    .busy         (ifb)
  );

  assign smask = 32'(miss_be) << {miss_dw, 3'h0};
  assign fmask = `L1RMH_DW_BYTES << {fill_beat, 3'h0};
  assign rld_data = rdb.rdata;

  for (gi = 0; gi < 32; gi++)
  begin : g_bits
    assign sbits[8*gi +: 8] = {8{smask[gi]}};
  end

  for (gi = 0; gi < `L1RMH_NENT; gi++)
  begin : g_ent
    assign hit[gi]  = ev[gi] && (eaddr[gi] == miss_addr);
    assign full[gi] = (ebv[gi] == `L1RMH_BLK_FULL);
    assign rdy[gi]  = ev[gi] && full[gi] && ecoh[gi] &&
                      (erq[gi] != RQ_GRANT) && !lref[gi];
  end

  // Entries still referenced by a folded load
  always_comb
  begin
    lref = 8'h0;
    for (int q = 0; q < `L1RMH_NLFQ; q++)
    begin
      if (lv[q])
      begin
        lref[ltag[q]] = 1'h1;
      end
    end
  end

  // Priority encoders over entries and fold queue slots
  always_comb
  begin
    {mh, ff, rf, pf, lf, qf} = 6'h0;
    {hidx, fidx, ridx, pidx} = 12'h0;
    {lfidx, qidx} = 4'h0;
    bvq = 8'h0;
    for (int i = `L1RMH_NENT - 1; i >= 0; i--)
    begin
      if (hit[i]) begin mh = 1'h1; hidx = 3'(i); end
      if (!ev[i]) begin ff = 1'h1; fidx = 3'(i); end
      if (rdy[i]) begin rf = 1'h1; ridx = 3'(i); end
      if (epend[i]) begin pf = 1'h1; pidx = 3'(i); end
    end
    for (int q = `L1RMH_NLFQ - 1; q >= 0; q--)
    begin
      bvq = 8'(ebv[ltag[q]] >> {ldw[q], 3'h0});
      if (!lv[q]) begin lf = 1'h1; lfidx = 2'(q); end
      if (lv[q] && ((bvq & lbe[q]) == lbe[q]))
      begin
        qf = 1'h1;
        qidx = 2'(q);
      end
    end
  end

  // Reload table, fold queue, buffer port and bus request
  always_comb
  begin
    next_ev = ev;
    next_eci = eci;
    next_est = est;
    next_egbl = egbl;
    next_esr = esr;
    next_ecoh = ecoh;
    next_epend = epend;
    next_eaddr = eaddr;
    next_ebv = ebv;
    next_esm = esm;
    next_erq = erq;
    next_epk = epk;
    next_lv = lv;
    next_ltag = ltag;
    next_ldw = ldw;
    next_lbe = lbe;
    next_lid = lid;
    next_ack = 1'h0;
    rdb.we = 1'h0;
    rdb.wentry = fill_entry;
    rdb.wmask = 32'h0;
    rdb.wdata = {4{fill_data}};
    rdb.re = 1'h0;
    rdb.rentry = ridx;
    next_rv = 1'h0;
    next_ra = eaddr[ridx];
    next_mcd = est[ridx];
    next_s1v = 1'h0;
    next_s1dw = ldw[qidx];
    next_s1id = lid[qidx];
    next_bv = 1'h0;
    next_be = pidx;
    next_bk = epk[pidx];
    next_ba = eaddr[pidx];
    // Issue one pending bus request
    if (pf)
    begin
      next_bv = 1'h1;
      next_epend[pidx] = 1'h0;
      if (erq[pidx] == RQ_NONE)
      begin
        next_erq[pidx] = RQ_WAIT;
      end
    end
    // Buffer read: reload first, then a folded load
    if (rf)
    begin
      rdb.re = 1'h1;
      next_ev[ridx] = 1'h0;
      next_rv = !eci[ridx];
    end
    else if (qf)
    begin
      rdb.re = 1'h1;
      rdb.rentry = ltag[qidx];
      next_lv[qidx] = 1'h0;
      next_s1v = 1'h1;
    end
    // Fill beats only complete bytes not yet written by stores
    if (fill_valid && ev[fill_entry])
    begin
      rdb.we = 1'h1;
      rdb.wmask = fmask & ~ebv[fill_entry];
      next_ebv[fill_entry] = ebv[fill_entry] | fmask;
    end
    if (fill_valid && fill_last && erq[fill_entry] == RQ_GRANT)
    begin
      next_erq[fill_entry] = RQ_NONE;
    end
    if (bq_bot_valid && bq_grant && erq[bq_bot_entry] == RQ_WAIT)
    begin
      next_erq[bq_bot_entry] = RQ_GRANT;
    end
    if (coh_ok && ev[coh_entry])
    begin
      next_ecoh[coh_entry] = 1'h1;
    end
    for (int i = 0; i < `L1RMH_NENT; i++)
    begin
      if (ev[i] && est[i] && !esr[i] && full[i])
      begin
        if (epend[i] && epk[i] == BK_RWITM)
        begin
          next_epend[i] = egbl[i];
          next_epk[i] = BK_KILL;
        end
        else if (erq[i] == RQ_WAIT &&
                 !(bq_bot_valid && bq_bot_entry == 3'(i) && bq_grant))
        begin
          next_erq[i] = RQ_REPL;
          next_epend[i] = 1'h1;
          if (bq_bot_valid && bq_bot_entry == 3'(i))
          begin
            next_epk[i] = BK_KILL;
          end
          else
          begin
            next_epk[i] = egbl[i] ? BK_KILL : BK_CANCEL;
          end
        end
      end
    end
    if (snoop_lose && ev[snoop_entry] && esr[snoop_entry] &&
        !ecoh[snoop_entry])
    begin
      next_esr[snoop_entry] = 1'h0;
      next_ebv[snoop_entry] = esm[snoop_entry];
      next_epend[snoop_entry] = 1'h1;
      next_epk[snoop_entry] = BK_RWITM;
      next_erq[snoop_entry] = RQ_NONE;
    end
    // Accept one miss request; stall while resources are busy
    if (miss_valid && !miss_ack)
    begin
      if (!miss_store && mh && lf && !eci[hidx])
      begin
        next_ack = 1'h1;
        next_lv[lfidx] = 1'h1;
        next_ltag[lfidx] = hidx;
        next_ldw[lfidx] = miss_dw;
        next_lbe[lfidx] = miss_be;
        next_lid[lfidx] = miss_tag;
      end
      else if (!miss_store && !mh && ff && lf)
      begin
        next_ack = 1'h1;
        next_ev[fidx] = 1'h1;
        next_eci[fidx] = miss_ci;
        next_est[fidx] = 1'h0;
        next_esr[fidx] = 1'h0;
        next_egbl[fidx] = miss_gbl;
        next_ecoh[fidx] = 1'h1;
        next_eaddr[fidx] = miss_addr;
        next_ebv[fidx] = 32'h0;
        next_esm[fidx] = 32'h0;
        next_erq[fidx] = RQ_NONE;
        next_epend[fidx] = 1'h1;
        next_epk[fidx] = BK_READ;
        next_lv[lfidx] = 1'h1;
        next_ltag[lfidx] = fidx;
        next_ldw[lfidx] = miss_dw;
        next_lbe[lfidx] = miss_be;
        next_lid[lfidx] = miss_tag;
      end
      else if (miss_store && !miss_sr && mh && est[hidx] &&
               !eci[hidx] && !fill_valid)
      begin
        next_ack = 1'h1;
        rdb.we = 1'h1;
        rdb.wentry = hidx;
        rdb.wmask = smask;
        rdb.wdata = {4{miss_wdata}};
        next_ebv[hidx] = ebv[hidx] | smask;
        next_esm[hidx] = esm[hidx] | smask;
      end
      else if (miss_store && !mh && ff && !fill_valid)
      begin
        next_ack = 1'h1;
        next_ev[fidx] = 1'h1;
        next_eci[fidx] = 1'h0;
        next_est[fidx] = 1'h1;
        next_esr[fidx] = miss_sr;
        next_egbl[fidx] = miss_gbl;
        next_ecoh[fidx] = !miss_gbl && !miss_sr;
        next_eaddr[fidx] = miss_addr;
        next_esm[fidx] = smask;
        next_erq[fidx] = RQ_NONE;
        next_epend[fidx] = 1'h1;
        next_epk[fidx] = miss_sr ? BK_KILL : BK_RWITM;
        rdb.we = 1'h1;
        rdb.wentry = fidx;
        if (miss_sr)
        begin
          rdb.wmask = `L1RMH_BLK_FULL;
          rdb.wdata = (miss_line & ~sbits) | ({4{miss_wdata}} & sbits);
          next_ebv[fidx] = `L1RMH_BLK_FULL;
        end
        else
        begin
          rdb.wmask = smask;
          rdb.wdata = {4{miss_wdata}};
          next_ebv[fidx] = smask;
        end
      end
    end
  end

  always_comb
  begin
    next_zcnt = (zcnt != 2'h0) ? zcnt - 2'h1 : zcnt;
    if (zhit_req && zcnt == 2'h0)
    begin
      next_zcnt = `L1RMH_ZHIT_GAP;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      {ev, eci, est, egbl, esr, ecoh, epend} <= 56'h0;
      eaddr <= '{default: 27'h0};
      ebv <= '{default: 32'h0};
      esm <= '{default: 32'h0};
      erq <= '{default: RQ_NONE};
      epk <= '{default: BK_READ};
      lv <= 4'h0;
      ltag <= '{default: 3'h0};
      ldw <= '{default: 2'h0};
      lbe <= '{default: 8'h0};
      lid <= '{default: 4'h0};
      {s1v, s1dw, s1id} <= 7'h0;
      miss_ack <= 1'h0;
      {breq_valid, breq_entry, breq_addr} <= 31'h0;
      breq_kind <= BK_READ;
      {rld_valid, rld_addr, rld_mcd} <= 29'h0;
      {res_valid, res_tag, res_data} <= 69'h0;
      {co_valid, co_l2_write, co_l2_new_tag, co_sys} <= 4'h0;
      {sthit_ack, zhit_ack, zcnt} <= 4'h0;
      l2en <= `L1RMH_L2EN_RST;
      reg_rdata <= 32'h0;
    end
    else if (ce)
    begin
      {ev, eci, est, egbl} <= {next_ev, next_eci, next_est, next_egbl};
      {esr, ecoh, epend} <= {next_esr, next_ecoh, next_epend};
      eaddr <= next_eaddr;
      ebv <= next_ebv;
      esm <= next_esm;
      erq <= next_erq;
      epk <= next_epk;
      lv <= next_lv;
      ltag <= next_ltag;
      ldw <= next_ldw;
      lbe <= next_lbe;
      lid <= next_lid;
      {s1v, s1dw, s1id} <= {next_s1v, next_s1dw, next_s1id};
      miss_ack <= next_ack;
      {breq_valid, breq_entry, breq_addr} <= {next_bv, next_be, next_ba};
      breq_kind <= next_bk;
      {rld_valid, rld_addr, rld_mcd} <= {next_rv, next_ra, next_mcd};
      res_valid <= s1v;
      res_tag <= s1id;
      res_data <= 64'(rdb.rdata >> {s1dw, 6'h0});
      // Castout choice; data misses never allocate in L2
      co_valid <= vic_valid && (vic_c || vic_d);
      co_l2_write <= vic_valid && (vic_c || vic_d) && l2en &&
                     vic_l2hit;
      co_l2_new_tag <= vic_valid && (vic_c || vic_d) && l2en &&
                       !vic_l2hit && vic_c;
      co_sys <= vic_valid && vic_m && (l2en ?
                (vic_c || vic_d) && !vic_l2hit && !vic_c
                : 1'h1);
      sthit_ack <= sthit_req;
      zhit_ack <= zhit_req && zcnt == 2'h0;
      zcnt <= next_zcnt;
      if (reg_wr && reg_addr == `L1RMH_CTRL_OFS)
      begin
        l2en <= reg_wdata[`L1RMH_L2EN_BIT];
      end
      reg_rdata <= 32'h0;
      if (reg_rd && reg_addr == `L1RMH_CTRL_OFS)
      begin
        reg_rdata <= 32'(l2en) << `L1RMH_L2EN_BIT;
      end
      else if (reg_rd && reg_addr == `L1RMH_STAT_OFS)
      begin
        reg_rdata <= 32'(ev) | (32'(lv) << `L1RMH_ST_LFQ) |
                     (32'(ifb) << `L1RMH_ST_IFB);
      end
    end
  end
endmodule

// [sim/l1rmh_top_props.sv]
// Concurrent checks on the reload handler top ports
`timescale 1ns/100ps
module l1rmh_props (
  input logic        ref_clk,
  input logic        rstn,
  input logic        ce,
  input logic        zhit_ack,
  input logic        sthit_req,
  input logic        sthit_ack,
  input logic        ibeat_valid,
  input logic        ic_wr,
  input logic        iq_valid,
  input logic [63:0] ic_wdata,
  input logic [63:0] iq_data,
  input logic        imiss_valid,
  input logic        imiss_l2miss,
  input logic        il2_alloc,
  input logic        vic_valid,
  input logic        vic_c,
  input logic        vic_m,
  input logic        vic_l2hit,
  input logic        co_l2_new_tag,
  input logic        co_sys,
  input logic        miss_valid,
  input logic        miss_ack
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_ZGAP: assert property (zhit_ack |=> !zhit_ack [*3])
    else $error("zero hit ack too soon");
  AST_SHIT: assert property (sthit_req && ce |=> sthit_ack)
    else $error("store hit not acked");
  AST_IQ: assert property (ic_wr |-> iq_valid && iq_data == ic_wdata)
    else $error("cache write and queue differ");
  AST_IBEAT: assert property (ic_wr |-> $past(ibeat_valid))
    else $error("cache write without beat");
  AST_IL2: assert property (il2_alloc |-> $past(imiss_valid && imiss_l2miss))
    else $error("bad L2 allocate");
  AST_CONEW: assert property (co_l2_new_tag |-> $past(vic_valid && vic_c && !vic_l2hit))
    else $error("bad new tag");
  AST_COSYS: assert property (co_sys |-> $past(vic_valid && vic_m))
    else $error("unmodified block sent out");
  AST_ACK: assert property (miss_ack |-> $past(miss_valid) ##1 !miss_ack)
    else $error("bad miss ack");
  cover property (zhit_ack ##4 zhit_ack);
  cover property (miss_ack);
  cover property (co_sys);
endmodule
bind l1rmh_top l1rmh_props u_props (.*);

// [sim/l1rmh_l2_model.sv]
// Stand-in for the L2 and bus unit: coherency, grant and fill beats
`timescale 1ns/100ps
module l1rmh_l2_model (
  input  logic        ref_clk,
  input  int          dly,
  input  logic        breq_valid,
  input  logic [2:0]  breq_entry,
  input  logic [1:0]  breq_kind,
  output logic        fill_valid,
  output logic        fill_last,
  output logic [2:0]  fill_entry,
  output logic [1:0]  fill_beat,
  output logic [63:0] fill_data,
  output logic        bq_bot_valid,
  output logic [2:0]  bq_bot_entry,
  output logic        bq_grant,
  output logic        coh_ok,
  output logic [2:0]  coh_entry
);
  logic [1:0] k;
  initial
  begin
    {fill_valid, fill_last, bq_bot_valid, bq_grant, coh_ok} = '0;
    {fill_entry, fill_beat, bq_bot_entry, coh_entry, fill_data} = '0;
    forever
    begin
      @(posedge ref_clk);
      k = breq_kind;
      if (breq_valid && k != 2'h3)
      begin
        fill_entry <= breq_entry;
        coh_entry <= breq_entry;
        bq_bot_entry <= breq_entry;
        bq_bot_valid <= 1'h1;
        repeat (dly) @(posedge ref_clk);
        bq_grant <= 1'h1;
        coh_ok <= 1'h1;
        @(posedge ref_clk);
        {bq_bot_valid, bq_grant, coh_ok} <= '0;
        // Burst after coherency; kill is address only
        for (int b = 0; b < 4 && k != 2'h2; b++)
        begin
          fill_valid <= 1'h1;
          fill_last <= b == 3;
          fill_beat <= b[1:0];
          fill_data <= {16{2'h2, b[1:0]}};
          @(posedge ref_clk);
        end
        fill_valid <= 1'h0;
        fill_last <= 1'h0;
        fill_data <= ~fill_data;
      end
    end
  end
endmodule

// [sim/l1rmh_top_tb.sv]
// Self-checking bench for the reload and miss handler
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITF(s) begin w = 0; while (s !== 1'h1 && w < 200) begin cyc(); \
  w++; end if (w >= 200) begin err_count++; finish_test(); end end
module l1rmh_top_tb;
  import l1rmh_pkg::*;
  logic ref_clk, rstn, ce, reg_wr, reg_rd, miss_valid, miss_store, miss_sr;
  logic miss_ci, miss_gbl, fill_valid, fill_last, bq_bot_valid, bq_grant;
  logic coh_ok, snoop_lose, vic_valid, vic_c, vic_d, vic_m, vic_l2hit;
  logic sthit_req, zhit_req, imiss_valid, imiss_l2miss, ibeat_valid;
  logic ihit_req, miss_ack, breq_valid, rld_valid, rld_mcd, res_valid;
  logic co_valid, co_l2_write, co_l2_new_tag, co_sys, sthit_ack, zhit_ack;
  logic ic_wr, iq_valid, il2_alloc, ihit_ack;
  logic [1:0] miss_dw, fill_beat, imiss_crit, ic_widx;
  logic [2:0] fill_entry, bq_bot_entry, coh_entry, snoop_entry, breq_entry;
  logic [3:0] reg_addr, miss_tag, res_tag;
  logic [7:0] miss_be;
  logic [26:0] miss_addr, breq_addr, rld_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [63:0] miss_wdata, fill_data, ibeat_data, ic_wdata, iq_data, res_data;
  logic [255:0] miss_line, rld_data;
  l1rmh_bk_t breq_kind;
  int err_count, cmp_count, w, n, m;
  l1rmh_top dut (.*);
  l1rmh_l2_model l2m (.dly(3), .*);
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cyc();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    cyc();
    reg_wr <= 1'h0;
    cyc();
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'h1;
    cyc();
    rv = reg_rdata;
    reg_rd <= 1'h0;
    cyc();
  endtask
  task automatic t_co();
    rd(4'hC);
    `CHK(rv, 32'h0)
    wr(4'h0, 32'h1);
    rd(4'h0);
    `CHK(rv, 32'h1)
    {vic_valid, vic_c, vic_d, vic_m, vic_l2hit} <= 5'h18;
    cyc();
    `CHK({co_valid, co_l2_new_tag, co_sys}, 3'h6)
    {vic_valid, vic_c, vic_d, vic_m, vic_l2hit} <= 5'h17;
    cyc();
    `CHK({co_valid, co_l2_write, co_l2_new_tag, co_sys}, 4'hC)
    vic_valid <= 1'h0;
    wr(4'h0, 32'h0);
    {vic_valid, vic_c, vic_d, vic_m, vic_l2hit} <= 5'h16;
    cyc();
    `CHK({co_valid, co_sys}, 2'h3)
    vic_valid <= 1'h0;
  endtask
  task automatic t_hit();
    {n, m} = '0;
    {zhit_req, sthit_req} <= 2'h3;
    repeat (8)
    begin
      cyc();
      n += zhit_ack;
      m += sthit_ack;
    end
    {zhit_req, sthit_req} <= 2'h0;
    `CHK({n, m}, {32'd2, 32'd8})
  endtask
  task automatic t_load();
    miss_addr <= 27'h0123456;
    miss_dw <= 2'h2;
    miss_be <= 8'hFF;
    miss_tag <= 4'h5;
    miss_valid <= 1'h1;
    `WAITF(miss_ack)
    miss_valid <= 1'h0;
    `WAITF(breq_valid)
    `CHK({breq_kind, breq_addr}, {BK_READ, 27'h0123456})
    `WAITF(res_valid)
    `CHK({res_tag, res_data}, {4'h5, {16{4'hA}}})
    `WAITF(rld_valid)
    `CHK({rld_mcd, rld_addr}, {1'h0, 27'h0123456})
    `CHK(rld_data, {{16{4'hB}}, {16{4'hA}}, {16{4'h9}}, {16{4'h8}}})
  endtask
  task automatic t_ifill();
    {imiss_crit, imiss_l2miss, imiss_valid, ihit_req} <= 5'h0F;
    cyc();
    `CHK(il2_alloc, 1'h1)
    imiss_valid <= 1'h0;
    rd(4'h4);
    `CHK(rv, 32'h00001000)
    ibeat_valid <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      ibeat_data <= {8{i[7:0]}};
      cyc();
      `CHK({ic_wr, iq_valid, ihit_ack, ic_widx}, {3'h7, i[1:0] + 2'h1})
      `CHK({ic_wdata, iq_data}, {16{i[7:0]}})
    end
    {ibeat_valid, ihit_req} <= 2'h0;
  endtask
  initial
  begin
    {rstn, reg_addr, reg_wdata, reg_wr, reg_rd, miss_valid, miss_store} = '0;
    {miss_sr, miss_ci, miss_gbl, miss_addr, miss_dw, miss_be, miss_wdata} = '0;
    {miss_line, miss_tag, snoop_lose, snoop_entry, sthit_req, zhit_req} = '0;
    {vic_valid, vic_c, vic_d, vic_m, vic_l2hit, ibeat_valid, ibeat_data} = '0;
    {imiss_valid, imiss_crit, imiss_l2miss, ihit_req} = '0;
    ce = 1'h1;
    repeat (8) cyc();
    rstn <= 1'h1;
    cyc();
    t_co();
    t_hit();
    t_load();
    t_ifill();
    cyc();
    finish_test();
  end
endmodule
